//--- rtl/sysctl_regs.svh
// register offsets, field positions, reset values and timing counts of the system control block
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

// register offsets (word registers on the plain port)
`define OFS_STATUS_WORD   4'h0
`define OFS_IRQ_ENABLE    4'h1
`define OFS_IRQ_PENDING   4'h2
`define OFS_IRQ_COND      4'h3
`define OFS_UART_IRQ_CTRL 4'h4
`define OFS_HALT_ENABLE   4'h5
`define OFS_SENSE_CFG     4'h6
`define OFS_MODE_STATUS   4'h7

// status word fields
`define SW_FULL_RANGE     0
`define SW_WAIT_LO        1
`define SW_WAIT_HI        2
`define SW_HALT           3
`define SW_IDLE           4
`define SW_SAVED_GIE      5

// irq enable fields: bit 0 global, bits 2..7 per source
`define IE_GLOBAL         0

// uart irq control fields
`define UC_RCV_EN         0
`define UC_XMIT_EN        1

// reset values
`define RST_STATUS_WORD   16'h0000
`define RST_IRQ_ENABLE    16'h0000

// address map
`define ADR_RAM_TOP       16'h02ff
`define ADR_EXT_LOW       16'h0300
`define ADR_ROM_BASE      16'hc000

// vector table base, rank n sits at base - 2n
`define VEC_RESET         16'hfffe
`define VEC_LAST          16'hfff0

// stack step on acknowledge
`define STACK_STEP        16'h0002

// internal rom wait: one state at full clock rate
`define ROM_MIN_WAIT      2'h1

// free-running timer: prescale clock by 16, overflow at wrap
`define TIMER_PRESCALE    4'hf

`endif

//--- rtl/sysctl_pkg.sv
// types of the system control block
package sysctl_pkg;
  typedef enum logic [1:0]
  {
    MODE_SC_NORMAL  = 2'b00,
    MODE_EXP_NORMAL = 2'b01,
    MODE_SC_ROMLESS = 2'b10,
    MODE_EXP_ROMLESS = 2'b11
  } op_mode_t;

  typedef enum logic [1:0]
  {
    PWR_RUN  = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_HALT = 2'b10
  } pwr_state_t;

  typedef enum logic [1:0]
  {
    SENSE_FALL = 2'b00,
    SENSE_RISE = 2'b01,
    SENSE_LOW  = 2'b10,
    SENSE_HIGH = 2'b11
  } sense_t;
endpackage : sysctl_pkg

//--- rtl/mode_power_interrupt_control.sv
// operating mode, external bus control, power save and interrupt arbitration
`timescale 1ns/100ps
`default_nettype none
`include "sysctl_regs.svh"

module mode_power_interrupt_control
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  // cpu bus request
  input  wire logic                 bus_req,
  input  wire logic                 bus_write,
  input  wire logic [15:0]          bus_addr,
  input  wire logic [15:0]          pc_in,
  input  wire logic [15:0]          sp_in,
  input  wire logic                 instr_done,
  input  wire logic                 ready_in,
  output logic                      bus_busy,
  output logic                      fetch_internal,
  output logic                      access_external,
  // external bus control
  input  wire logic                 offchip_rom_select,
  input  wire logic                 upper_byte_strobe_in,
  output logic                      upper_byte_strobe_out,
  output logic                      upper_byte_strobe_oe,
  output logic                      ext_bus_enable,
  output logic                      addr_latch_strobe,
  output logic                      read_strobe,
  output logic                      write_strobe,
  output logic                      bus_16bit,
  output logic                      supervisor_fault_out,
  // interrupt pins
  input  wire logic                 nmi_pin,
  input  wire logic                 irq_pin_two,
  input  wire logic                 irq_pin_three,
  input  wire logic                 irq_pin_four,
  input  wire logic                 cfg_sense_irq_pin,
  input  wire logic                 shared_serial_irq_pin,
  input  wire logic                 uart_irq,
  // interrupt acknowledge to cpu
  output logic                      irq_take,
  output logic [15:0]               irq_vector,
  output logic [15:0]               stack_push_pc,
  output logic [15:0]               next_sp,
  // power state
  output logic                      core_stopped,
  output logic                      timer_run,
  output sysctl_pkg::pwr_state_t    pwr_state
);
  import sysctl_pkg::*;

  logic [15:0] proc_status_word;
  logic [15:0] irq_enable_reg;
  logic [7:0]  irq_pending_reg;
  logic [2:0]  irq_cond;
  logic [1:0]  uart_irq_ctrl_reg;
  logic [1:0]  sense_cfg;
  logic        halt_allowed;
  logic        halt_en_locked;
  logic        boot_pending;
  logic [3:0]  prescale;
  logic [15:0] free_run_timer;
  logic        timer_ovf;
  logic [7:0]  pin_prev;
  logic [1:0]  wait_cnt;
  logic        cyc_active;
  logic        nmi_held;
  op_mode_t    op_mode;
  logic        full_range_bit;
  logic        global_irq_enable;
  logic        saved_global_enable;
  logic        adr_ram;
  logic        adr_rom;
  logic        adr_legal;
  logic        rom_int;
  logic        off_chip;
  logic [7:0]  trig;
  logic [7:0]  req;
  logic [2:0]  win_rank;
  logic        any_req;
  logic [1:0]  wait_sel;
  logic        nmi_edge;

  assign full_range_bit      = proc_status_word[`SW_FULL_RANGE];
  assign global_irq_enable   = irq_enable_reg[`IE_GLOBAL];
  assign saved_global_enable = proc_status_word[`SW_SAVED_GIE];

  // mode decode from pin and status bit, evaluated every cycle
  assign op_mode  = op_mode_t'({offchip_rom_select, full_range_bit});
  assign adr_ram  = (bus_addr <= `ADR_RAM_TOP);
  assign adr_rom  = (bus_addr >= `ADR_ROM_BASE);
  assign rom_int  = adr_rom && !offchip_rom_select;
  assign adr_legal = full_range_bit || adr_ram || adr_rom;
  assign off_chip = !adr_ram && !rom_int && adr_legal;
  assign fetch_internal  = (pc_in >= `ADR_ROM_BASE) && !offchip_rom_select;
  assign access_external = bus_req && off_chip;
  assign ext_bus_enable  = (op_mode != MODE_SC_NORMAL);

  // wait count: status bits, floor of one for internal rom
  always_comb
  begin
    wait_sel = proc_status_word[`SW_WAIT_HI:`SW_WAIT_LO];
    if (rom_int && wait_sel < `ROM_MIN_WAIT)
      wait_sel = `ROM_MIN_WAIT;
  end

  // bus cycle sequencer, stretched by waits and ready
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cyc_active <= 1'b0;
      wait_cnt   <= 2'h0;
    end
    else if (pwr_state == PWR_RUN)
    begin
      if (!cyc_active && bus_req && adr_legal)
      begin
        cyc_active <= 1'b1;
        wait_cnt   <= wait_sel;
      end
      else if (cyc_active && wait_cnt != 2'h0)
        wait_cnt <= wait_cnt - 2'h1;
      else if (cyc_active && ready_in)
        cyc_active <= 1'b0;
    end
  end
  assign bus_busy = cyc_active;

  // external strobes, only for off-chip addresses
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_latch_strobe <= 1'b0;
      read_strobe       <= 1'b0;
      write_strobe      <= 1'b0;
    end
    else
    begin
      addr_latch_strobe <= ext_bus_enable && !cyc_active && access_external
                           && pwr_state == PWR_RUN;
      read_strobe       <= ext_bus_enable && cyc_active && off_chip && !bus_write;
      write_strobe      <= ext_bus_enable && cyc_active && off_chip && bus_write;
    end
  end
  assign upper_byte_strobe_out = bus_16bit && cyc_active && off_chip && bus_addr[0];
  assign upper_byte_strobe_oe  = ext_bus_enable && bus_16bit && !boot_pending;

  // bus width strap caught in the first cycle after reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_pending <= 1'b1;
      bus_16bit    <= 1'b1;
    end
    else if (boot_pending)
    begin
      boot_pending <= 1'b0;
      bus_16bit    <= !upper_byte_strobe_in;
    end
  end

  // illegal address fault, held until reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      supervisor_fault_out <= 1'b0;
    else if (bus_req && !adr_legal)
      supervisor_fault_out <= 1'b1;
  end

  // free-running timer at clock/16, stopped only in halt
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prescale       <= 4'h0;
      free_run_timer <= 16'h0000;
    end
    else if (pwr_state != PWR_HALT)
    begin
      prescale <= prescale + 4'h1;
      if (prescale == `TIMER_PRESCALE)
        free_run_timer <= free_run_timer + 16'h0001;
    end
  end
  assign timer_ovf = (prescale == `TIMER_PRESCALE) && (free_run_timer == 16'hffff)
                     && pwr_state != PWR_HALT;
  assign timer_run = (pwr_state != PWR_HALT);

  // trigger detection per source
  assign nmi_edge = nmi_pin && !pin_prev[1];
  always_comb
  begin
    trig    = 8'h00;
    trig[1] = nmi_edge;
    trig[2] = irq_cond[0] ? (irq_pin_two && !pin_prev[2]) : (!irq_pin_two && pin_prev[2]);
    trig[3] = irq_cond[1] ? (irq_pin_three && !pin_prev[3])
                          : (!irq_pin_three && pin_prev[3]);
    trig[4] = irq_cond[2] ? (irq_pin_four && !pin_prev[4]) : (!irq_pin_four && pin_prev[4]);
    trig[5] = timer_ovf;
    trig[6] = !shared_serial_irq_pin || (uart_irq && |uart_irq_ctrl_reg);
    unique case (sense_t'(sense_cfg))
      SENSE_FALL: trig[7] = !cfg_sense_irq_pin && pin_prev[7];
      SENSE_RISE: trig[7] = cfg_sense_irq_pin && !pin_prev[7];
      SENSE_LOW:  trig[7] = !cfg_sense_irq_pin;
      SENSE_HIGH: trig[7] = cfg_sense_irq_pin;
    endcase
  end

  // previous pin levels for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_prev <= 8'h00;
    else
      pin_prev <= {cfg_sense_irq_pin, 2'b00, irq_pin_four, irq_pin_three, irq_pin_two,
                   nmi_pin, 1'b0};
  end

  // request qualification: nmi unmaskable, others gated
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_req
      if (g < 2)
        assign req[g] = irq_pending_reg[g];
      else
        assign req[g] = irq_pending_reg[g] && irq_enable_reg[g] && global_irq_enable;
    end
  endgenerate

  // fixed-priority arbiter, lowest rank wins
  always_comb
  begin
    win_rank = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (req[i])
        win_rank = i[2:0];
  end
  assign any_req = |req;
  // acknowledge after the instruction ends, not during the entry instruction's nmi
  assign irq_take   = any_req && instr_done && (pwr_state == PWR_RUN) && !nmi_held;
  assign irq_vector = `VEC_RESET - {12'h000, win_rank, 1'b0};
  assign stack_push_pc = pc_in;
  assign next_sp       = sp_in + `STACK_STEP;

  // pending flags: set on trigger, cleared on service or, for ranks 2 to 7 only, on software zero write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_pending_reg <= 8'h00;
    else
    begin
      for (int i = 1; i < 8; i++)
      begin
        if (trig[i])
          irq_pending_reg[i] <= 1'b1;
        else if (irq_take && win_rank == i[2:0])
          irq_pending_reg[i] <= 1'b0;
        else if (reg_wr && reg_addr == `OFS_IRQ_PENDING && i > 1 && !reg_wdata[i])
          irq_pending_reg[i] <= 1'b0;
      end
    end
  end

  // power state machine with halt gating and nmi exit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_state <= PWR_RUN;
      nmi_held  <= 1'b0;
    end
    else
    begin
      unique case (pwr_state)
        PWR_RUN:
        begin
          nmi_held <= 1'b0;
          if (reg_wr && reg_addr == `OFS_STATUS_WORD && reg_wdata[`SW_HALT] && halt_allowed)
          begin
            pwr_state <= PWR_HALT;
            nmi_held  <= nmi_edge;
          end
          else if (reg_wr && reg_addr == `OFS_STATUS_WORD && reg_wdata[`SW_IDLE])
          begin
            pwr_state <= PWR_IDLE;
            nmi_held  <= nmi_edge;
          end
        end
        PWR_IDLE:
          if (nmi_edge || timer_ovf)
          begin
            pwr_state <= PWR_RUN;
            nmi_held  <= 1'b0;
          end
        PWR_HALT:
          if (nmi_edge)
          begin
            pwr_state <= PWR_RUN;
            nmi_held  <= 1'b0;
          end
        default:
          pwr_state <= PWR_RUN;
      endcase
    end
  end
  assign core_stopped = (pwr_state != PWR_RUN);

  // software registers and interrupt acknowledge side effects
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      proc_status_word  <= `RST_STATUS_WORD;
      irq_enable_reg    <= `RST_IRQ_ENABLE;
      irq_cond          <= 3'h0;
      uart_irq_ctrl_reg <= 2'h0;
      sense_cfg         <= 2'h0;
      halt_allowed      <= 1'b0;
      halt_en_locked    <= 1'b0;
    end
    else if (irq_take)
    begin
      proc_status_word[`SW_SAVED_GIE] <= global_irq_enable;
      irq_enable_reg[`IE_GLOBAL]      <= 1'b0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `OFS_STATUS_WORD:   proc_status_word <= {reg_wdata[15:5], 2'b00, reg_wdata[2:0]};
        `OFS_IRQ_ENABLE:    irq_enable_reg   <= reg_wdata;
        `OFS_IRQ_COND:      irq_cond         <= reg_wdata[2:0];
        `OFS_UART_IRQ_CTRL: uart_irq_ctrl_reg <= reg_wdata[1:0];
        `OFS_SENSE_CFG:     sense_cfg        <= reg_wdata[1:0];
        `OFS_HALT_ENABLE:
          if (!halt_en_locked)
          begin
            halt_allowed   <= reg_wdata[0];
            halt_en_locked <= 1'b1;
          end
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      unique case (reg_addr)
        `OFS_STATUS_WORD:   reg_rdata <= proc_status_word;
        `OFS_IRQ_ENABLE:    reg_rdata <= irq_enable_reg;
        `OFS_IRQ_PENDING:   reg_rdata <= {8'h00, irq_pending_reg};
        `OFS_IRQ_COND:      reg_rdata <= {13'h0, irq_cond};
        `OFS_UART_IRQ_CTRL: reg_rdata <= {14'h0, uart_irq_ctrl_reg};
        `OFS_HALT_ENABLE:   reg_rdata <= {14'h0, halt_en_locked, halt_allowed};
        `OFS_SENSE_CFG:     reg_rdata <= {14'h0, sense_cfg};
        `OFS_MODE_STATUS:   reg_rdata <= {10'h0, pwr_state, bus_16bit, supervisor_fault_out,
                                          op_mode};
        default:            reg_rdata <= 16'h0000;
      endcase
    else
      reg_rdata <= 16'h0000;
  end

  // checks
  AST_ROM_INTERNAL: assert property (@(posedge clk) disable iff (!arst_n)
    (pc_in >= `ADR_ROM_BASE && !offchip_rom_select) |-> fetch_internal)
    else $error("internal rom fetch missing");
  AST_ROM_EXTERNAL: assert property (@(posedge clk) disable iff (!arst_n)
    offchip_rom_select |-> !fetch_internal)
    else $error("internal fetch with select high");
  AST_FAULT_ILLEGAL: assert property (@(posedge clk) disable iff (!arst_n)
    (bus_req && !full_range_bit && !adr_ram && !adr_rom) |=> supervisor_fault_out)
    else $error("illegal address not flagged");
  AST_NO_STROBE_INT: assert property (@(posedge clk) disable iff (!arst_n)
    (cyc_active && !off_chip) |=> !read_strobe && !write_strobe)
    else $error("strobe on internal access");
  AST_ROM_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
    (!cyc_active && bus_req && rom_int && pwr_state == PWR_RUN) |=> cyc_active[*2])
    else $error("rom access shorter than one wait");
  sequence s_halt_entry;
    pwr_state == PWR_RUN ##1 pwr_state == PWR_HALT;
  endsequence
  AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (s_halt_entry ##0 !nmi_edge) |=> pwr_state == PWR_HALT)
    else $error("halt left without nmi");
  AST_HALT_ONCE: assert property (@(posedge clk) disable iff (!arst_n)
    (halt_en_locked && reg_wr && reg_addr == `OFS_HALT_ENABLE) |=> $stable(halt_allowed))
    else $error("halt enable changed twice");
  AST_ACK_GIE: assert property (@(posedge clk) disable iff (!arst_n)
    irq_take |=> !global_irq_enable && saved_global_enable == $past(global_irq_enable))
    else $error("global enable not saved on ack");
  AST_PENDING_SET: assert property (@(posedge clk) disable iff (!arst_n)
    trig[5] |=> irq_pending_reg[5])
    else $error("pending flag not set");
  AST_PENDING_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
    trig[2] |=> irq_pending_reg[2])
    else $error("edge pending flag not set");
  AST_MASKED: assert property (@(posedge clk) disable iff (!arst_n)
    (irq_take && win_rank > 3'h1) |-> global_irq_enable)
    else $error("masked source taken");
endmodule : mode_power_interrupt_control
`default_nettype wire

//--- tb/ext_mem_model.sv
// external memory model on the far side of the bus control strobes
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // bus strobes from the block
  input  wire logic read_strobe,
  input  wire logic write_strobe,
  input  wire logic hb_out,
  input  wire logic hb_oe,
  input  wire logic slow,
  // answers to the block
  output logic      ready_in,
  output logic      hb_pin
);
  logic [1:0] stall;
  logic       strobe_prev;

  // pull-up on the high byte pin selects the 8-bit bus at reset
  assign hb_pin = hb_oe ? hb_out : 1'b1;

  // slow memory holds ready low for two cycles after a strobe starts;
  // a strobe that stays high must not re-arm the stall or the cycle never ends
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      stall       <= 2'h0;
      strobe_prev <= 1'b0;
    end
    else
    begin
      strobe_prev <= read_strobe || write_strobe;
      if ((read_strobe || write_strobe) && !strobe_prev && slow)
        stall <= 2'h2;
      else if (stall != 2'h0)
        stall <= stall - 2'h1;
    end

  assign ready_in = (stall == 2'h0);
endmodule : ext_mem_model
`default_nettype wire

//--- tb/mode_power_interrupt_control_tb.sv
// self-checking testbench of the system control block
`timescale 1ns/100ps
`default_nettype none
`include "sysctl_regs.svh"
module mode_power_interrupt_control_tb;
  import sysctl_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, bus_addr = 16'h0000, pc_in = 16'h0000;
  logic [15:0] sp_in = 16'h0100, reg_rdata, irq_vector, stack_push_pc, next_sp, rv;
  logic bus_req = 1'b0, bus_write = 1'b0, instr_done = 1'b0, sel = 1'b0, nmi = 1'b0;
  logic irq_two = 1'b0, slow = 1'b1, ready_in, hb_pin, hb_out, hb_oe, seen, ale;
  logic bus_busy, fetch_internal, access_external, ext_bus_enable, addr_latch_strobe;
  logic read_strobe, write_strobe, bus_16bit, fault, irq_take, core_stopped, timer_run;
  pwr_state_t pwr_state;
  int err_total = 0, compares = 0, n;

  always #5 clk = ~clk;

  mode_power_interrupt_control i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .pc_in(pc_in),
    .sp_in(sp_in), .instr_done(instr_done), .ready_in(ready_in), .bus_busy(bus_busy),
    .fetch_internal(fetch_internal), .access_external(access_external),
    .offchip_rom_select(sel), .upper_byte_strobe_in(hb_pin),
    .upper_byte_strobe_out(hb_out), .upper_byte_strobe_oe(hb_oe),
    .ext_bus_enable(ext_bus_enable), .addr_latch_strobe(addr_latch_strobe),
    .read_strobe(read_strobe), .write_strobe(write_strobe), .bus_16bit(bus_16bit),
    .supervisor_fault_out(fault), .nmi_pin(nmi), .irq_pin_two(irq_two),
    .irq_pin_three(1'b0), .irq_pin_four(1'b0), .cfg_sense_irq_pin(1'b0),
    .shared_serial_irq_pin(1'b1), .uart_irq(1'b0), .irq_take(irq_take),
    .irq_vector(irq_vector), .stack_push_pc(stack_push_pc), .next_sp(next_sp),
    .core_stopped(core_stopped), .timer_run(timer_run), .pwr_state(pwr_state));

  ext_mem_model i_mem (.clk(clk), .arst_n(arst_n), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .hb_out(hb_out), .hb_oe(hb_oe), .slow(slow),
    .ready_in(ready_in), .hb_pin(hb_pin));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // cpu bus request held for twelve clocks, which can run several bus cycles; reports whether a read or write strobe appeared
  task automatic bus_cyc(input logic w, input logic [15:0] a);
    seen = 1'b0;
    ale = 1'b0;
    @(posedge clk);
    bus_req <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    for (n = 0; n < 12; n++)
    begin
      @(negedge clk);
      seen = seen | read_strobe | write_strobe;
      ale = ale | addr_latch_strobe;
    end
    @(posedge clk);
    bus_req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : bus_cyc

  task automatic t_reset;
    rd(`OFS_STATUS_WORD);
    check(rv, `RST_STATUS_WORD);
    rd(`OFS_IRQ_ENABLE);
    check(rv, `RST_IRQ_ENABLE);
    rd(4'hf);
    check(rv, 16'h0000);
    rd(`OFS_MODE_STATUS);
    check({15'h0, rv[3]}, 16'h0000);
    check({15'h0, bus_busy}, 16'h0000);
  endtask : t_reset

  task automatic t_modes;
    for (int j = 0; j < 4; j++)
    begin
      int i;
      i = {30'h0, j[0], ~j[1]}; // expanded modes first, the fault is sticky
      @(posedge clk);
      sel <= i[1];
      pc_in <= `ADR_ROM_BASE;
      wr(`OFS_STATUS_WORD, {15'h0, i[0]});
      rd(`OFS_MODE_STATUS);
      check({14'h0, rv[1:0]}, i[15:0]);
      check({15'h0, fetch_internal}, {15'h0, ~i[1]});
      check({15'h0, ext_bus_enable}, {15'h0, i != 0});
      bus_cyc(1'b0, 16'h0100);
      check({15'h0, seen}, 16'h0000);
      bus_cyc(1'b1, 16'h8000);
      check({15'h0, seen}, {15'h0, i[0]});
      check({15'h0, ale}, {15'h0, i[0]});
      bus_cyc(1'b0, 16'he000);
      check({15'h0, seen}, {15'h0, i[1]});
      if (j == 1)
        check({15'h0, fault}, 16'h0000);
    end
    check({15'h0, fault}, 16'h0001);
  endtask : t_modes

  task automatic t_irq;
    wr(`OFS_IRQ_COND, 16'h0001);
    wr(`OFS_IRQ_ENABLE, 16'h0004);
    @(posedge clk);
    irq_two <= 1'b1;
    instr_done <= 1'b1;
    repeat (3) @(posedge clk);
    instr_done <= 1'b0;
    check({15'h0, irq_take}, 16'h0000);
    rd(`OFS_IRQ_PENDING);
    check({15'h0, rv[2]}, 16'h0001);
    check({15'h0, rv[7]}, 16'h0000);
    wr(`OFS_IRQ_ENABLE, 16'h0005);
    @(posedge clk);
    instr_done <= 1'b1;
    @(negedge clk);
    check({15'h0, irq_take}, 16'h0001);
    check(irq_vector, `VEC_RESET - 16'h0004);
    check(next_sp, sp_in + `STACK_STEP);
    check(stack_push_pc, pc_in);
    @(posedge clk);
    instr_done <= 1'b0;
    rd(`OFS_IRQ_ENABLE);
    check({15'h0, rv[`IE_GLOBAL]}, 16'h0000);
    rd(`OFS_STATUS_WORD);
    check({15'h0, rv[`SW_SAVED_GIE]}, 16'h0001);
    wr(`OFS_SENSE_CFG, 16'h0002);
    rd(`OFS_IRQ_PENDING);
    check({15'h0, rv[7]}, 16'h0001);
  endtask : t_irq

  task automatic t_power;
    wr(`OFS_HALT_ENABLE, 16'h0001);
    wr(`OFS_HALT_ENABLE, 16'h0000);
    rd(`OFS_HALT_ENABLE);
    check({15'h0, rv[0]}, 16'h0001);
    for (int k = 0; k < 2; k++)
    begin
      wr(`OFS_STATUS_WORD, k == 0 ? 16'h0008 : 16'h0010);
      @(negedge clk);
      check({14'h0, pwr_state}, k == 0 ? 16'h0002 : 16'h0001);
      check({15'h0, core_stopped}, 16'h0001);
      check({15'h0, timer_run}, {15'h0, k == 1});
      @(posedge clk);
      nmi <= 1'b1;
      repeat (3) @(posedge clk);
      nmi <= 1'b0;
      @(negedge clk);
      check({14'h0, pwr_state}, 16'h0000);
    end
  endtask : t_power

  task automatic t_fault;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({15'h0, fault}, 16'h0000);
    sel <= 1'b0;
    wr(`OFS_STATUS_WORD, 16'h0000);
    bus_cyc(1'b0, 16'h0400);
    check({15'h0, fault}, 16'h0001);
  endtask : t_fault

  task automatic wrap_up;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_modes();
    t_irq();
    t_power();
    t_fault();
    wrap_up();
  end
endmodule : mode_power_interrupt_control_tb
`default_nettype wire
